// >>> msg_framer_pkg.sv
package msg_framer_pkg;
	// Message geometry
	localparam int unsigned WORD_W         = 16;
	localparam int unsigned HDR_WORDS      = 6;
	localparam int unsigned MSG_BITS_MAX   = 16384;
	localparam int unsigned MAX_DATA_WORDS = MSG_BITS_MAX / WORD_W;
	localparam int unsigned IDX_W          = 11;
	localparam logic [2:0]  HDR_LAST       = 3'h5;
	localparam logic [IDX_W-1:0] HDR_END   = IDX_W'(HDR_WORDS);
	localparam logic [IDX_W-1:0] MAX_IDX   = IDX_W'(HDR_WORDS + MAX_DATA_WORDS - 1);

	// Header field positions
	localparam int unsigned W0_CLASS   = 15;
	localparam int unsigned W0_LOOP    = 14;
	localparam int unsigned W0_ADVPRI  = 12;
	localparam int unsigned W3_MODE    = 15;
	localparam int unsigned W3_DERR    = 12;
	localparam int unsigned W3_PRI     = 8;
	localparam logic        NODE_LOOP  = 1'b1;

	// Register map, byte addresses
	localparam int unsigned ADDR_W     = 4;
	localparam logic [3:0]  REG_CTRL   = 4'h0;
	localparam logic [3:0]  REG_STATUS = 4'h4;
	localparam logic [3:0]  REG_DROPS  = 4'h8;

	// Control fields
	localparam int unsigned CTRL_AR    = 0;
	localparam int unsigned CTRL_MSB   = 1;
	localparam int unsigned CTRL_ADVPRI = 2;
	localparam logic [3:0]  CTRL_RESET = 4'h0;

	// Status fields
	localparam int unsigned ST_STICKY  = 3;
	localparam logic [2:0]  ST_RESET   = 3'h0;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum {RX_HDR, RX_EMIT, RX_PASS, RX_DROP} rx_state_t;
	typedef enum {TX_FILL, TX_HDR, TX_PASS} tx_state_t;

	// Header sum that both directions share
	function automatic logic [15:0] hdr_sum(input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] c, input logic [15:0] d, input logic [15:0] e);
		return 16'(a + b + c + d + e);
	endfunction

	function automatic logic [15:0] rev16(input logic [15:0] w);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			r[i] = w[15-i];
		end
		return r;
	endfunction
endpackage

// >>> word_serialiser.sv
`timescale 1ns/1ps
module word_serialiser (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        load,
	input  wire logic [15:0] word,
	input  wire logic        msb_first,
	input  wire logic        last,
	output logic             ser_bit,
	output logic             ser_en,
	output logic             ser_end,
	output logic             busy
);
	import msg_framer_pkg::*;

	logic [15:0] sh_q;
	logic [3:0]  cnt_q;
	logic        busy_q;
	logic        msb_q;
	logic        last_q;
	logic        bit_q;
	logic        en_q;
	logic        end_q;

	// Shift direction fixed per word so a mode change never splits one
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sh_q   <= 16'h0000;
			cnt_q  <= 4'h0;
			busy_q <= 1'b0;
			msb_q  <= 1'b0;
			last_q <= 1'b0;
			bit_q  <= 1'b0;
			en_q   <= 1'b0;
			end_q  <= 1'b0;
		end else if (busy_q) begin
			bit_q  <= msb_q ? sh_q[15] : sh_q[0];
			sh_q   <= msb_q ? {sh_q[14:0], 1'b0} : {1'b0, sh_q[15:1]};
			en_q   <= 1'b1;
			end_q  <= last_q && (cnt_q == 4'hf);
			cnt_q  <= cnt_q + 4'h1;
			busy_q <= (cnt_q != 4'hf); // Always all sixteen bits
		end else begin
			en_q   <= 1'b0;
			end_q  <= 1'b0;
			if (load) begin
				sh_q   <= word;
				cnt_q  <= 4'h0;
				busy_q <= 1'b1;
				msb_q  <= msb_first;
				last_q <= last;
			end
		end
	end

	assign ser_bit = bit_q;
	assign ser_en  = en_q;
	assign ser_end = end_q;
	assign busy    = busy_q;
endmodule // word_serialiser

// >>> msg_framer.sv
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module msg_framer (
	input  wire logic                              ref_clk,
	input  wire logic                              rst,
	input  wire logic [msg_framer_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                              s_axi_awvalid,
	output logic                                   s_axi_awready,
	input  wire logic [31:0]                       s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	input  wire logic                              s_axi_wvalid,
	output logic                                   s_axi_wready,
	output logic [1:0]                             s_axi_bresp,
	output logic                                   s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	input  wire logic [msg_framer_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                              s_axi_arvalid,
	output logic                                   s_axi_arready,
	output logic [31:0]                            s_axi_rdata,
	output logic [1:0]                             s_axi_rresp,
	output logic                                   s_axi_rvalid,
	input  wire logic                              s_axi_rready,
	input  wire logic                              link_rx_bit,
	input  wire logic                              link_rx_en,
	input  wire logic                              link_rx_end,
	output logic                                   link_tx_bit,
	output logic                                   link_tx_en,
	output logic                                   link_tx_end,
	input  wire logic [15:0]                       tx_in_word,
	input  wire logic                              tx_in_valid,
	input  wire logic                              tx_in_last,
	output logic                                   tx_in_ready,
	input  wire logic                              tx_data_err,
	output logic [15:0]                            rx_out_word,
	output logic                                   rx_out_valid,
	output logic                                   rx_out_last,
	output logic                                   rx_out_abort,
	output logic                                   rx_out_stream,
	output logic [1:0]                             rx_out_pri,
	output logic                                   ar_valid,
	output logic [7:0]                             ar_num,
	output logic                                   ar_accept,
	output logic                                   hdr_err
);
	import msg_framer_pkg::*;

	// Bus state
	logic                    awready_q;
	logic                    wready_q;
	logic                    bvalid_q;
	logic [1:0]              bresp_q;
	logic                    arready_q;
	logic                    rvalid_q;
	logic [1:0]              rresp_q;
	logic [31:0]             rdata_q;
	logic [ADDR_W-1:0]       awaddr_q;
	logic [31:0]             wdata_q;
	logic [3:0]              wstrb_q;
	logic [3:0]              ctrl_q;
	logic [2:0]              sticky_q;
	logic [15:0]             drops_q;
	logic [1:0]              peer_q;
	// Receive state
	rx_state_t               rx_state_q;
	logic [IDX_W-1:0]        rx_idx_q;
	logic [2:0]              emit_q;
	logic                    end_seen_q;
	logic [15:0]             rsh_q;
	logic [3:0]              rbit_q;
	logic [15:0]             hdr_q [HDR_WORDS];
	logic [15:0]             out_word_q;
	logic                    out_valid_q;
	logic                    out_last_q;
	logic                    out_abort_q;
	logic                    out_stream_q;
	logic [1:0]              out_pri_q;
	logic                    ar_valid_q;
	logic [7:0]              ar_num_q;
	logic                    ar_accept_q;
	logic                    hdr_err_q;
	// Transmit state
	tx_state_t               tx_state_q;
	logic [2:0]              tidx_q;
	logic                    tx_end_q;
	logic                    tx_ready_q;
	logic [15:0]             thdr_q [HDR_WORDS];
	logic                    ser_load_q;
	logic [15:0]             ser_word_q;
	logic                    ser_last_q;
	logic                    ser_busy;

	function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
		return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_DROPS);
	endfunction

	// Bus decode
	wire        wr_fire   = ~awready_q & ~wready_q & ~bvalid_q;
	wire        wr_ctrl   = wr_fire & (awaddr_q == REG_CTRL) & wstrb_q[0];
	wire        wr_status = wr_fire & (awaddr_q == REG_STATUS) & wstrb_q[0];
	wire        rd_take   = s_axi_arvalid & arready_q;
	wire        ctrl_ar   = ctrl_q[CTRL_AR];
	wire        ctrl_msb  = ctrl_q[CTRL_MSB];
	wire [1:0]  go_pri    = ctrl_q[CTRL_ADVPRI +: 2];
	wire        rx_busy   = (rx_state_q != RX_HDR) | (rx_idx_q != '0);
	wire        tx_busy   = (tx_state_q != TX_FILL);
	wire [31:0] status_w  = {22'h00_0000, tx_busy, rx_busy, 2'h0, peer_q, 1'b0, sticky_q};
	wire [31:0] rd_mux    = (s_axi_araddr == REG_CTRL)   ? {28'h000_0000, ctrl_q} :
	                        (s_axi_araddr == REG_STATUS) ? status_w :
	                        (s_axi_araddr == REG_DROPS)  ? {16'h0000, drops_q} : 32'h0000_0000;

	// Write channel: address and data latch apart, answer once both are held
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			awaddr_q  <= '0;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_q) begin
				awready_q <= 1'b0;
				awaddr_q  <= s_axi_awaddr;
			end else if (wr_fire) begin
				awready_q <= 1'b1;
			end
			if (s_axi_wvalid && wready_q) begin
				wready_q <= 1'b0;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end else if (wr_fire) begin
				wready_q <= 1'b1;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= reg_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Read channel: one read at a time, data captured at the address edge
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
		end else if (rd_take) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_mux;
			rresp_q   <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// Receive decode: one switch for acceptance gates both directions
	wire [15:0] rx_lsb    = {link_rx_bit, rsh_q[15:1]};
	wire [15:0] rx_word   = ctrl_msb ? rev16(rx_lsb) : rx_lsb;
	wire        rx_wdone  = link_rx_en & (rbit_q == 4'hf);
	wire        rx_end    = link_rx_en & link_rx_end;
	wire        rx_hlast  = (rx_state_q == RX_HDR) & rx_wdone & (rx_idx_q == IDX_W'(HDR_LAST));
	wire [15:0] rx_sum    = 16'(hdr_sum(hdr_q[0], hdr_q[2], hdr_q[3], hdr_q[4], rx_word) + hdr_q[1]);
	wire        rx_ok     = rx_hlast & (rx_sum == 16'h0000);
	wire        rx_bad    = rx_hlast & (rx_sum != 16'h0000);
	wire        is_data   = ~hdr_q[0][W0_CLASS];
	wire [1:0]  rx_pri    = hdr_q[3][W3_PRI +: 2];
	wire        rx_keep   = rx_ok & (~is_data | (rx_pri >= go_pri));
	wire        rx_report = rx_ok & is_data & ctrl_ar & (hdr_q[0][7:0] != 8'h00);
	wire        rx_loop   = rx_ok & (hdr_q[0][W0_LOOP] == NODE_LOOP);
	wire        emit_fire = (rx_state_q == RX_EMIT) & ~rx_end;
	wire        pass_fire = (rx_state_q == RX_PASS) & rx_wdone;
	wire        rx_long   = pass_fire & (rx_idx_q == MAX_IDX) & ~rx_end;
	wire        rx_part   = ((rx_state_q == RX_EMIT) | (rx_state_q == RX_PASS)) & rx_end & ~rx_wdone;
	wire        rx_abort  = rx_part | rx_long;
	wire [2:0]  st_set    = {rx_abort, rx_loop, rx_bad};
	wire [2:0]  st_clr    = wr_status ? wdata_q[ST_STICKY-1:0] : ST_RESET;

	// Control, sticky flags (set beats clear) and drop counter
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_q   <= CTRL_RESET;
			sticky_q <= ST_RESET;
			drops_q  <= 16'h0000;
			peer_q   <= 2'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= wdata_q[3:0];
			end
			sticky_q <= (sticky_q & ~st_clr) | st_set;
			if (rx_bad) begin
				drops_q <= drops_q + 16'h0001;
			end
			if (rx_ok) begin
				peer_q <= hdr_q[0][W0_ADVPRI +: 2];
			end
		end
	end

	// Deserialiser; the link layer's end marker rides on the last bit
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rsh_q  <= 16'h0000;
			rbit_q <= 4'h0;
		end else if (link_rx_en) begin
			rsh_q  <= rx_lsb;
			rbit_q <= rx_end ? 4'h0 : rbit_q + 4'h1;
		end
	end

	// Header words land untouched, addresses included
	always_ff @(posedge ref_clk) begin
		if ((rx_state_q == RX_HDR) && rx_wdone && (rx_idx_q < HDR_END)) begin
			hdr_q[rx_idx_q[2:0]] <= rx_word;
		end
	end

	// Receive sequencer: nothing leaves before the checksum is known
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_state_q <= RX_HDR;
			rx_idx_q   <= '0;
			end_seen_q <= 1'b0;
		end else begin
			unique case (rx_state_q)
			RX_HDR: begin
				if (rx_hlast) begin
					rx_idx_q   <= (rx_end && !rx_keep) ? '0 : HDR_END;
					end_seen_q <= rx_end;
					if (rx_keep) begin
						rx_state_q <= RX_EMIT;
					end else if (!rx_end) begin
						rx_state_q <= RX_DROP;
					end
				end else if (rx_end) begin
					rx_idx_q <= '0; // Runt or ragged header dies here
				end else if (rx_wdone) begin
					rx_idx_q <= rx_idx_q + 1'b1;
				end
			end
			RX_EMIT: begin
				if (rx_end) begin
					rx_state_q <= RX_HDR;
					rx_idx_q   <= '0;
				end else if (emit_q == HDR_LAST) begin
					rx_state_q <= end_seen_q ? RX_HDR : RX_PASS;
					rx_idx_q   <= end_seen_q ? '0 : HDR_END;
				end
			end
			RX_PASS: begin
				if (rx_end) begin
					rx_state_q <= RX_HDR;
					rx_idx_q   <= '0;
				end else if (rx_long) begin
					rx_state_q <= RX_DROP;
				end else if (rx_wdone) begin
					rx_idx_q <= rx_idx_q + 1'b1;
				end
			end
			RX_DROP: begin
				if (rx_end) begin
					rx_state_q <= RX_HDR;
					rx_idx_q   <= '0;
				end
			end
			endcase
		end
	end

	// Replay header in order, then pass data words
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			emit_q       <= 3'h0;
			out_word_q   <= 16'h0000;
			out_valid_q  <= 1'b0;
			out_last_q   <= 1'b0;
			out_abort_q  <= 1'b0;
			out_stream_q <= 1'b0;
			out_pri_q    <= 2'h0;
			ar_valid_q   <= 1'b0;
			ar_num_q     <= 8'h00;
			ar_accept_q  <= 1'b0;
			hdr_err_q    <= 1'b0;
		end else begin
			emit_q      <= (rx_state_q == RX_EMIT) ? emit_q + 3'h1 : 3'h0;
			out_valid_q <= emit_fire | pass_fire;
			out_word_q  <= (rx_state_q == RX_EMIT) ? hdr_q[emit_q] : rx_word;
			out_last_q  <= (emit_fire & (emit_q == HDR_LAST) & end_seen_q) | (pass_fire & rx_end);
			out_abort_q <= rx_abort;
			hdr_err_q   <= rx_bad;
			ar_valid_q  <= rx_report;
			if (rx_report) begin
				ar_num_q    <= hdr_q[0][7:0];
				ar_accept_q <= rx_keep;
			end
			if (rx_keep) begin
				out_stream_q <= is_data & hdr_q[3][W3_MODE];
				out_pri_q    <= rx_pri;
			end
		end
	end

	// Transmit header edits: loop bit, advisory, acceptance fields, error flag
	wire        tx_take   = tx_in_valid & tx_ready_q;
	wire        ser_idle  = ~ser_busy & ~ser_load_q;
	wire        tx_isdata = ~thdr_q[0][W0_CLASS];
	wire [7:0]  tx_num    = ctrl_ar ? tx_in_word[7:0] : 8'h00;
	wire [15:0] tx_w0     = {tx_in_word[15], NODE_LOOP, go_pri, tx_in_word[11:8], tx_num};
	wire        tx_derr   = tx_isdata ? tx_data_err : tx_in_word[W3_DERR];
	wire [15:0] tx_w3     = {tx_in_word[15:13], tx_derr, tx_in_word[11:0]};
	wire [15:0] tx_fill   = (tidx_q == 3'h0) ? tx_w0 :
	                        (tidx_q == 3'h2) ? (ctrl_ar ? tx_in_word : 16'h0000) :
	                        (tidx_q == 3'h3) ? tx_w3 : tx_in_word;
	wire [15:0] tx_cksum  = 16'(16'h0000 - hdr_sum(thdr_q[0], thdr_q[2], thdr_q[3],
	                        thdr_q[4], thdr_q[5]));

	always_ff @(posedge ref_clk) begin
		if ((tx_state_q == TX_FILL) && tx_take) begin
			thdr_q[tidx_q] <= tx_fill;
		end
	end

	// Transmit sequencer: header must be whole before its checksum exists
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_state_q <= TX_FILL;
			tidx_q     <= 3'h0;
			tx_end_q   <= 1'b0;
		end else begin
			unique case (tx_state_q)
			TX_FILL: begin
				if (tx_take && (tidx_q == HDR_LAST)) begin
					tx_state_q <= TX_HDR;
					tidx_q     <= 3'h0;
					tx_end_q   <= tx_in_last;
				end else if (tx_take) begin
					tidx_q <= tx_in_last ? 3'h0 : tidx_q + 3'h1; // Short header discarded
				end
			end
			TX_HDR: begin
				if (ser_idle && (tidx_q == HDR_LAST)) begin
					tx_state_q <= tx_end_q ? TX_FILL : TX_PASS;
					tidx_q     <= 3'h0;
				end else if (ser_idle) begin
					tidx_q <= tidx_q + 3'h1;
				end
			end
			TX_PASS: begin
				if (tx_take && tx_in_last) begin
					tx_state_q <= TX_FILL;
				end
			end
			endcase
		end
	end

	// Ready and serialiser loads; data waits on the shifter, no buffer
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_ready_q <= 1'b0;
			ser_load_q <= 1'b0;
			ser_word_q <= 16'h0000;
			ser_last_q <= 1'b0;
		end else begin
			if (tx_take && ((tx_state_q == TX_PASS) || (tidx_q == HDR_LAST))) begin
				tx_ready_q <= 1'b0;
			end else if ((tx_state_q == TX_FILL) || ((tx_state_q == TX_PASS) && ser_idle)) begin
				tx_ready_q <= 1'b1;
			end
			ser_load_q <= ((tx_state_q == TX_HDR) && ser_idle) || ((tx_state_q == TX_PASS) && tx_take);
			if ((tx_state_q == TX_HDR) && ser_idle) begin
				ser_word_q <= (tidx_q == 3'h1) ? tx_cksum : thdr_q[tidx_q];
				ser_last_q <= tx_end_q && (tidx_q == HDR_LAST);
			end else if ((tx_state_q == TX_PASS) && tx_take) begin
				ser_word_q <= tx_in_word;
				ser_last_q <= tx_in_last;
			end
		end
	end

	word_serialiser u_ser (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.load      (ser_load_q),
		.word      (ser_word_q),
		.msb_first (ctrl_msb),
		.last      (ser_last_q),
		.ser_bit   (link_tx_bit),
		.ser_en    (link_tx_en),
		.ser_end   (link_tx_end),
		.busy      (ser_busy)
	);

	// Outputs straight from their flops
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign tx_in_ready   = tx_ready_q;
	assign rx_out_word   = out_word_q;
	assign rx_out_valid  = out_valid_q;
	assign rx_out_last   = out_last_q;
	assign rx_out_abort  = out_abort_q;
	assign rx_out_stream = out_stream_q;
	assign rx_out_pri    = out_pri_q;
	assign ar_valid      = ar_valid_q;
	assign ar_num        = ar_num_q;
	assign ar_accept     = ar_accept_q;
	assign hdr_err       = hdr_err_q;

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire ser_w_lsb = ser_word_q[0];
	wire ser_w_msb = ser_word_q[15];
	sequence eight_bits;
		link_tx_en [*8];
	endsequence

	chk_word_whole: assert property (
		ser_load_q |-> ##2 eight_bits ##1 eight_bits ##1 !link_tx_en)
		else $error("word not sent as sixteen bits");
	chk_lsb_first: assert property (
		(ser_load_q && !ctrl_msb) |-> ##2 (link_tx_bit == $past(ser_w_lsb, 2)))
		else $error("first bit is not bit 0");
	chk_msb_first: assert property (
		(ser_load_q && ctrl_msb) |-> ##2 (link_tx_bit == $past(ser_w_msb, 2)))
		else $error("first bit is not bit 15");
	chk_tx_loop_bit: assert property (
		(tx_state_q == TX_FILL && tx_take && tidx_q == 3'h0) |=> thdr_q[0][W0_LOOP] == NODE_LOOP)
		else $error("outgoing loop bit wrong");
	chk_tx_cksum: assert property (
		(tx_state_q == TX_HDR && ser_idle && tidx_q == 3'h1) |=>
		16'(ser_word_q + hdr_sum(thdr_q[0], thdr_q[2], thdr_q[3], thdr_q[4], thdr_q[5])) == 16'h0000)
		else $error("sent checksum does not cancel header");
	chk_rx_drop: assert property (
		rx_bad |=> (hdr_err_q && !out_valid_q) ##1 !out_valid_q [*6])
		else $error("bad header message delivered");
	chk_drop_count: assert property (
		rx_bad |=> drops_q == 16'($past(drops_q) + 16'h0001))
		else $error("drop count did not advance");
	chk_ar_report: assert property (
		rx_report |=> ar_valid_q && (ar_num_q == $past(hdr_q[0][7:0]))
			&& (ar_accept_q == $past(rx_keep)))
		else $error("acceptance report missing");
	chk_no_report: assert property (
		!ctrl_ar |=> !ar_valid_q || $past(rx_report))
		else $error("report sent with acceptance off");
	chk_prio_refuse: assert property (
		(rx_ok && is_data && rx_pri < go_pri) |=> rx_state_q != RX_EMIT)
		else $error("low priority message delivered");
endmodule // msg_framer

// >>> host_model.sv
`timescale 1ns/1ps
module host_model (
	input  wire logic ref_clk,
	output logic      rx_bit = 1'b0,
	output logic      rx_en  = 1'b0,
	output logic      rx_end = 1'b0,
	input  wire logic tx_bit,
	input  wire logic tx_en,
	input  wire logic tx_end
);
	logic [15:0] frm [0:7];
	logic [15:0] sh = 16'h0000;
	logic [15:0] got [$];
	int          cnt = 0;
	int          ends = 0;
	// Whole words ascending, bit 0 first; idle line flips so stale bits never match
	task automatic send(input int n);
		for (int w = 0; w < n; w++) begin
			for (int b = 0; b < 16; b++) begin
				@(posedge ref_clk);
				rx_en  <= 1'b1;
				rx_bit <= frm[w][b];
				rx_end <= (w == n - 1) && (b == 15);
			end
		end
		@(posedge ref_clk);
		rx_en  <= 1'b0;
		rx_end <= 1'b0;
		rx_bit <= ~rx_bit;
	endtask
	// Rebuild sent words, first bit lands in bit 0
	always @(posedge ref_clk) begin
		if (tx_en === 1'b1) begin
			sh = {tx_bit, sh[15:1]};
			cnt++;
			if (tx_end === 1'b1) ends++;
			if (cnt == 16) begin
				got.push_back(sh);
				cnt = 0;
			end
		end
	end
endmodule // host_model

// >>> msg_framer_bench.sv
`timescale 1ns/1ps
module msg_framer_bench;
	import msg_framer_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rx_out_pri, rr, br;
	logic s_axi_rvalid, link_rx_bit, link_rx_en, link_rx_end, link_tx_bit, link_tx_en;
	logic [15:0] tx_in_word = 16'h0000, rx_out_word;
	logic tx_in_valid = 1'b0, tx_in_last = 1'b0, tx_data_err = 1'b0, tx_in_ready, link_tx_end;
	logic rx_out_valid, rx_out_last, rx_out_abort, rx_out_stream, ar_valid, ar_accept, hdr_err;
	logic [7:0] ar_num;
	logic [8:0] ar_seen = 9'h000;
	logic [15:0] rxq [$];
	int failures = 0, n_compared = 0, n_err = 0, n_last = 0, n_abort = 0;
	msg_framer msg_framer_inst (.*);
	host_model host_model_inst (.ref_clk(ref_clk), .rx_bit(link_rx_bit), .rx_en(link_rx_en),
		.rx_end(link_rx_end), .tx_bit(link_tx_bit), .tx_en(link_tx_en), .tx_end(link_tx_end));
	always #20 ref_clk = ~ref_clk;
	// Gather delivered words, pulses and reports; each stands a single cycle
	always @(posedge ref_clk) begin
		if (rx_out_valid === 1'b1) rxq.push_back(rx_out_word);
		if (hdr_err === 1'b1) n_err++;
		if (rx_out_last === 1'b1) n_last++;
		if (rx_out_abort === 1'b1) n_abort++;
		if (ar_valid === 1'b1) ar_seen = {ar_accept, ar_num};
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Each channel is released at its own take; response closes the write
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		br = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [3:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic push(input logic [15:0] w, input logic l);
		@(posedge ref_clk);
		tx_in_word <= w;
		tx_in_valid <= 1'b1;
		tx_in_last <= l;
		do @(posedge ref_clk); while (tx_in_ready !== 1'b1);
		tx_in_valid <= 1'b0;
	endtask
	// Host-built data message; word 1 is the negated sum of words 0 and 2..5
	task automatic load_frame(input logic [15:0] w0, w1, w3);
		host_model_inst.frm = '{w0, w1, 16'h0000, w3, 16'haaaa,
			16'h5555, 16'h1357, 16'h0000};
		host_model_inst.send(7);
		repeat (20) @(posedge ref_clk);
	endtask
	task automatic t_regs();
		axi_read(REG_CTRL);
		check(rd[15:0], 16'h0000);
		axi_write(REG_CTRL, 32'h0000_000c);
		axi_read(REG_CTRL);
		check(rd[15:0], 16'h000c);
		axi_write(REG_CTRL, 32'h0000_0000);
		axi_read(4'hc);
		check({14'h0000, rr}, {14'h0000, RESP_SLVERR});
		axi_write(4'hc, 32'h0000_0000);
		check({14'h0000, br}, {14'h0000, RESP_SLVERR});
	endtask
	task automatic t_rx_good();
		load_frame(16'h0000, 16'hfd01, 16'h0300);
		check(16'(rxq.size()), 16'h0007);
		check(rxq[4], 16'haaaa);
		check(rxq[6], 16'h1357);
		check({14'h0000, rx_out_pri}, 16'h0003);
	endtask
	// A one-bit slip in the checksum must lose the whole frame
	task automatic t_rx_bad();
		load_frame(16'h0000, 16'hfd00, 16'h0300);
		check(16'(n_err), 16'h0001);
		check(16'(rxq.size()), 16'h0007);
		axi_read(REG_DROPS);
		check(rd[15:0], 16'h0001);
		axi_read(REG_STATUS);
		check(rd[15:0], 16'h0001);
	endtask
	// Acceptance on: kept stream message is accepted, a low priority one refused
	task automatic t_rx_ar();
		axi_write(REG_CTRL, 32'h0000_0001);
		load_frame(16'h0005, 16'h7cfc, 16'h8300);
		check({7'h00, ar_seen}, 16'h0105);
		check({15'h0000, rx_out_stream}, 16'h0001);
		check(rxq[7], 16'h0005);
		axi_write(REG_CTRL, 32'h0000_000d);
		load_frame(16'h0006, 16'hfffb, 16'h0000);
		check({7'h00, ar_seen}, 16'h0006);
		check(16'(rxq.size()), 16'h000e);
		check(16'(n_last), 16'h0002);
		check(16'(n_abort), 16'h0000);
		axi_write(REG_CTRL, 32'h0000_0000);
	endtask
	// Node forces loop bit, error flag and checksum: 4000+1100+1234+5678 sums to 16'hb9ac
	task automatic t_tx();
		tx_data_err <= 1'b1;
		push(16'h0000, 1'b0);
		push(16'h0000, 1'b0);
		push(16'h0000, 1'b0);
		push(16'h0100, 1'b0);
		push(16'h1234, 1'b0);
		push(16'h5678, 1'b0);
		push(16'h0013, 1'b1);
		while (host_model_inst.got.size() < 7) @(posedge ref_clk);
		check(host_model_inst.got[0], 16'h4000);
		check(host_model_inst.got[1], 16'h4654);
		check(host_model_inst.got[3], 16'h1100);
		check(host_model_inst.got[6], 16'h0013);
	endtask
	// Bit 15 first: header-only message, so the model's words come back reversed
	task automatic t_tx_msb();
		axi_write(REG_CTRL, 32'h0000_0002);
		for (int i = 0; i < 6; i++) begin
			push(16'h0000, i == 5);
		end
		while (host_model_inst.got.size() < 13) @(posedge ref_clk);
		check(host_model_inst.got[7], 16'h0002);
		check(host_model_inst.got[8], 16'h000d);
		check(host_model_inst.got[10], 16'h0008);
		check(16'(host_model_inst.ends), 16'h0002);
	endtask
	task automatic print_verdict();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		t_regs();
		t_rx_good();
		t_rx_bad();
		t_rx_ar();
		t_tx();
		t_tx_msb();
		print_verdict();
	end
	// Whole run needs well under 2000 cycles; this is ten times that
	initial begin
		#800_000;
		failures++;
		print_verdict();
	end
endmodule // msg_framer_bench
